// *** logic/tap_pkg.sv ***
// Overview of operation
// [RL1] Bypass stage loads zero leaving Capture-DR
// [RL2] Output enabled on falling edge in Shift-DR
// [RL3] Bypass delays serial stream by one clock
// [RL4] Output high impedance outside shift states
// [RL5] Update-DR falling edge loads parallel output
// [RL6] Three high mode selects return to reset
// [RL7] Sample on rising, drive on falling edges
// [RL8] All-ones instruction selects the bypass stage
`default_nettype none

package tap_pkg;

   // ----------------------------------------------------------------
   // Instruction register
   // ----------------------------------------------------------------
   localparam int IR_W = 8;
   localparam logic [IR_W-1:0] IR_CAPTURE = 8'h81;
   localparam logic [IR_W-1:0] IR_BYPASS = 8'hff;
   localparam logic [IR_W-1:0] IR_USER_DR = 8'h01;
   localparam logic [IR_W-1:0] IR_RESET = 8'hff;

   // ----------------------------------------------------------------
   // Data registers
   // ----------------------------------------------------------------
   localparam int DR_W = 8;
   localparam logic BYPASS_CAPTURE = 1'b0;
   localparam logic [DR_W-1:0] DR_RESET = 8'h00;

   // ----------------------------------------------------------------
   // Controller states
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_TLR,
      ST_RTI,
      ST_SEL_DR,
      ST_CAP_DR,
      ST_SHIFT_DR,
      ST_EXIT1_DR,
      ST_PAUSE_DR,
      ST_EXIT2_DR,
      ST_UPD_DR,
      ST_SEL_IR,
      ST_CAP_IR,
      ST_SHIFT_IR,
      ST_EXIT1_IR,
      ST_PAUSE_IR,
      ST_EXIT2_IR,
      ST_UPD_IR
   } tap_state_t;

endpackage

`default_nettype wire

// *** logic/sync_2ff.sv ***
`default_nettype none

module sync_2ff #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);

   logic [W-1:0] meta_q;

   // ----------------------------------------------------------------
   // Two stages; the first is read by the second only
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         meta_q <= INIT;
         q_o <= INIT;
      end else begin
         meta_q <= d_i;
         q_o <= meta_q;
      end
   end

endmodule

`default_nettype wire

// *** logic/tap_bypass_scan.sv ***
`default_nettype none

module tap_bypass_scan #(
   parameter int DW = tap_pkg::DR_W
) (
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire logic tck_i,
   input wire logic tms_i,
   input wire logic tdi_i,
   output logic tdo_o,
   output logic tdo_oe_n_o,
   output logic [DW-1:0] dr_par_o,
   output logic dr_upd_o,
   output logic tlr_o
);
   import tap_pkg::*;

   // ----------------------------------------------------------------
   // Reset brought into the test clock domain
   // ----------------------------------------------------------------
   logic trst_n;

   // Assert follows rstn_i only once tck runs; a stopped tck holds the TAP
   sync_2ff #(.W(1), .INIT(1'b0)) u_rst_sync (
      .clk_i(tck_i),
      .rst_n_i(rstn_i),
      .d_i(1'b1),
      .q_o(trst_n)
   );

   // ----------------------------------------------------------------
   // Controller state machine
   // ----------------------------------------------------------------
   tap_state_t state_q;
   tap_state_t state_d;

   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_TLR: state_d = tms_i ? ST_TLR : ST_RTI;
         ST_RTI: state_d = tms_i ? ST_SEL_DR : ST_RTI;
         ST_SEL_DR: state_d = tms_i ? ST_SEL_IR : ST_CAP_DR;
         ST_CAP_DR: state_d = tms_i ? ST_EXIT1_DR : ST_SHIFT_DR;
         ST_SHIFT_DR: state_d = tms_i ? ST_EXIT1_DR : ST_SHIFT_DR;
         ST_EXIT1_DR: state_d = tms_i ? ST_UPD_DR : ST_PAUSE_DR;
         ST_PAUSE_DR: state_d = tms_i ? ST_EXIT2_DR : ST_PAUSE_DR;
         ST_EXIT2_DR: state_d = tms_i ? ST_UPD_DR : ST_SHIFT_DR;
         ST_UPD_DR: state_d = tms_i ? ST_SEL_DR : ST_RTI;
         ST_SEL_IR: state_d = tms_i ? ST_TLR : ST_CAP_IR;
         ST_CAP_IR: state_d = tms_i ? ST_EXIT1_IR : ST_SHIFT_IR;
         ST_SHIFT_IR: state_d = tms_i ? ST_EXIT1_IR : ST_SHIFT_IR;
         ST_EXIT1_IR: state_d = tms_i ? ST_UPD_IR : ST_PAUSE_IR;
         ST_PAUSE_IR: state_d = tms_i ? ST_EXIT2_IR : ST_PAUSE_IR;
         ST_EXIT2_IR: state_d = tms_i ? ST_UPD_IR : ST_SHIFT_IR;
         ST_UPD_IR: state_d = tms_i ? ST_SEL_DR : ST_RTI;
         default: state_d = ST_TLR;
      endcase
   end

   // [RL7] Rising edge sampling
   always_ff @(posedge tck_i) begin
      if (!trst_n) begin
         state_q <= ST_TLR;
      end else begin
         state_q <= state_d;
      end
   end

   // Registered so the crossing sees no decode glitches
   logic tlr_q;

   always_ff @(posedge tck_i) begin
      if (!trst_n) begin
         tlr_q <= 1'b1;
      end else begin
         tlr_q <= (state_d == ST_TLR);
      end
   end

   // ----------------------------------------------------------------
   // Instruction register
   // ----------------------------------------------------------------
   logic [IR_W-1:0] ir_shift_q;
   logic [IR_W-1:0] ir_q;
   logic sel_bypass;
   logic sel_user;

   always_ff @(posedge tck_i) begin
      if (!trst_n) begin
         ir_shift_q <= IR_RESET;
      end else if (state_q == ST_CAP_IR) begin
         ir_shift_q <= IR_CAPTURE;
      end else if (state_q == ST_SHIFT_IR) begin
         ir_shift_q <= {tdi_i, ir_shift_q[IR_W-1:1]};
      end
   end

   // [RL8] Instruction update
   always_ff @(negedge tck_i) begin
      if (!trst_n || state_q == ST_TLR) begin
         ir_q <= IR_RESET;
      end else if (state_q == ST_UPD_IR) begin
         ir_q <= ir_shift_q;
      end
   end

   // Unknown codes fall back to bypass so a scan chain never breaks
   assign sel_user = (ir_q == IR_USER_DR);
   assign sel_bypass = !sel_user;

   // ----------------------------------------------------------------
   // Data registers
   // ----------------------------------------------------------------
   logic bypass_q;
   logic [DW-1:0] dr_shift_q;
   logic [DW-1:0] dr_par_q;
   logic upd_tgl_q;

   // [RL1] Bypass capture and shift
   always_ff @(posedge tck_i) begin
      if (!trst_n) begin
         bypass_q <= BYPASS_CAPTURE;
      end else if (state_q == ST_CAP_DR && sel_bypass) begin
         bypass_q <= BYPASS_CAPTURE;
      end else if (state_q == ST_SHIFT_DR && sel_bypass) begin
         bypass_q <= tdi_i;
      end
   end

   always_ff @(posedge tck_i) begin
      if (!trst_n) begin
         dr_shift_q <= DR_RESET;
      end else if (state_q == ST_CAP_DR && sel_user) begin
         dr_shift_q <= dr_par_q;
      end else if (state_q == ST_SHIFT_DR && sel_user) begin
         dr_shift_q <= {tdi_i, dr_shift_q[DW-1:1]};
      end
   end

   // [RL5] Falling edge update
   always_ff @(negedge tck_i) begin
      if (!trst_n) begin
         dr_par_q <= DR_RESET;
         upd_tgl_q <= 1'b0;
      end else if (state_q == ST_UPD_DR && sel_user) begin
         dr_par_q <= dr_shift_q;
         upd_tgl_q <= !upd_tgl_q;
      end
   end

   // ----------------------------------------------------------------
   // Serial output, driven on falling edges
   // ----------------------------------------------------------------
   logic tdo_q;
   logic tdo_oe_n_q;
   logic shifting;

   assign shifting = (state_q == ST_SHIFT_DR) || (state_q == ST_SHIFT_IR);

   // [RL2] Enable in shift states
   // [RL4] Released elsewhere
   always_ff @(negedge tck_i) begin
      if (!trst_n) begin
         tdo_oe_n_q <= 1'b1;
      end else begin
         tdo_oe_n_q <= !shifting;
      end
   end

   // [RL3] One clock delay through bypass
   always_ff @(negedge tck_i) begin
      if (!trst_n) begin
         tdo_q <= 1'b0;
      end else if (state_q == ST_SHIFT_IR) begin
         tdo_q <= ir_shift_q[0];
      end else if (state_q == ST_SHIFT_DR) begin
         tdo_q <= sel_bypass ? bypass_q : dr_shift_q[0];
      end
   end

   assign tdo_o = tdo_q;
   assign tdo_oe_n_o = tdo_oe_n_q;

   // ----------------------------------------------------------------
   // Crossing into the core clock domain
   // ----------------------------------------------------------------
   logic upd_tgl_sync;
   logic upd_tgl_seen_q;
   logic tlr_sync;
   logic [DW-1:0] dr_par_out_q;
   logic dr_upd_q;

   sync_2ff #(.W(1), .INIT(1'b0)) u_upd_sync (
      .clk_i(core_clk_i),
      .rst_n_i(rstn_i),
      .d_i(upd_tgl_q),
      .q_o(upd_tgl_sync)
   );

   sync_2ff #(.W(1), .INIT(1'b1)) u_tlr_sync (
      .clk_i(core_clk_i),
      .rst_n_i(rstn_i),
      .d_i(tlr_q),
      .q_o(tlr_sync)
   );

   // Parallel word is stable for a full scan after its toggle flips
   always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
         upd_tgl_seen_q <= 1'b0;
         dr_par_out_q <= DR_RESET;
         dr_upd_q <= 1'b0;
      end else begin
         upd_tgl_seen_q <= upd_tgl_sync;
         dr_upd_q <= (upd_tgl_sync != upd_tgl_seen_q);
         if (upd_tgl_sync != upd_tgl_seen_q) begin
            dr_par_out_q <= dr_par_q;
         end
      end
   end

   logic tlr_out_q;

   always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
         tlr_out_q <= 1'b1;
      end else begin
         tlr_out_q <= tlr_sync;
      end
   end

   assign dr_par_o = dr_par_out_q;
   assign dr_upd_o = dr_upd_q;
   assign tlr_o = tlr_out_q;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   bypass_capture_a: assert property ( // [RL1]
      @(posedge tck_i) disable iff (!trst_n)
      (state_q == ST_CAP_DR && sel_bypass) |=> (bypass_q == 1'b0))
      else $error("bypass stage did not capture zero");

   tdo_enable_a: assert property ( // [RL2]
      @(posedge tck_i) disable iff (!trst_n)
      (state_q == ST_SHIFT_DR) |-> (tdo_oe_n_q == 1'b0))
      else $error("serial output not enabled in shift");

   first_zero_a: assert property ( // [RL3]
      @(posedge tck_i) disable iff (!trst_n)
      (state_q == ST_SHIFT_DR && sel_bypass && $past(state_q) == ST_CAP_DR)
      |-> (tdo_q == 1'b0))
      else $error("captured zero not shifted out first");

   bypass_delay_a: assert property ( // [RL3]
      @(posedge tck_i) disable iff (!trst_n)
      (state_q == ST_SHIFT_DR && sel_bypass && $past(state_q) == ST_SHIFT_DR)
      |-> (tdo_q == $past(tdi_i)))
      else $error("bypass delay is not one clock");

   tdo_hiz_a: assert property ( // [RL4]
      @(posedge tck_i) disable iff (!trst_n)
      (state_q == ST_EXIT1_DR) ##1 (state_q != ST_SHIFT_DR) [*2]
      |-> tdo_oe_n_q && $past(tdo_oe_n_q))
      else $error("serial output driven outside shift");

   update_dr_a: assert property ( // [RL5]
      @(posedge tck_i) disable iff (!trst_n)
      (state_q == ST_UPD_DR && sel_user) |-> (dr_par_q == dr_shift_q))
      else $error("parallel output not updated");

   tlr_return_a: assert property ( // [RL6]
      @(posedge tck_i) disable iff (!trst_n)
      (state_q == ST_UPD_DR && tms_i) ##1 tms_i ##1 tms_i |=> (state_q == ST_TLR))
      else $error("three high mode selects missed reset");

   ir_bypass_a: assert property ( // [RL8]
      @(posedge tck_i) disable iff (!trst_n)
      (state_q == ST_UPD_IR && ir_shift_q == IR_BYPASS) |=> (ir_q == IR_BYPASS && sel_bypass))
      else $error("all-ones instruction did not select bypass");

   // Bypass scans must leave the parallel word alone
   bypass_no_update_a: assert property ( // [RL8]
      @(posedge tck_i) disable iff (!trst_n)
      (state_q == ST_UPD_DR && sel_bypass) |=> $stable(dr_par_q))
      else $error("bypass scan changed the parallel word");

   // Updates closer than a few core cycles would merge
   upd_pulse_a: assert property ( // [RL5]
      @(posedge core_clk_i) disable iff (!rstn_i)
      dr_upd_q |=> !dr_upd_q)
      else $error("update pulse longer than one cycle");

   bypass_scan_c: cover property (
      @(posedge tck_i) disable iff (!trst_n)
      (state_q == ST_SHIFT_DR && sel_bypass) ##1 (state_q == ST_EXIT1_DR)
      ##1 (state_q == ST_UPD_DR));

   ir_scan_c: cover property (
      @(posedge tck_i) disable iff (!trst_n)
      (state_q == ST_UPD_IR && ir_shift_q == IR_BYPASS));

   core_update_c: cover property (
      @(posedge core_clk_i) disable iff (!rstn_i)
      dr_upd_q);

   user_update_c: cover property (
      @(posedge tck_i) disable iff (!trst_n)
      (state_q == ST_UPD_DR && sel_user));

endmodule

`default_nettype wire

// *** dv/tap_ctrl_model.sv ***
`default_nettype none

module tap_ctrl_model (
   output logic tck_o,
   output logic tms_o,
   output logic tdi_o,
   input wire logic tdo_i,
   input wire logic tdo_oe_n_i
);
   timeunit 1ns;
   timeprecision 100ps;

   logic tdo_s;
   logic oe_n_s;

   initial begin
      tck_o = 1'b0;
      tms_o = 1'b1;
      tdi_o = 1'b0;
      tdo_s = 1'b0;
      oe_n_s = 1'b1;
   end

   // ---------------------------------------------
   // One test clock, 6 ns
   // ---------------------------------------------
   // change after fall, sample after next fall
   task automatic step(input logic m, input logic d);
      tms_o = m;
      tdi_o = d;
      #2 tck_o = 1'b1;
      #3 tck_o = 1'b0;
      // Released line floats; show the inverse so a stale bit is caught
      #1 tdo_s = tdo_oe_n_i ? ~tdo_i : tdo_i;
      oe_n_s = tdo_oe_n_i;
   endtask

   // Data in is not valid here, so toggle it
   task automatic idle(input logic m);
      step(m, ~tdi_o);
   endtask
endmodule

`default_nettype wire

// *** dv/test_tap_bypass_scan.sv ***
`default_nettype none

`define CHK(nm, e, a) begin checked++; if ((a) !== (e)) begin fail_count++; \
   $display("MISMATCH %s exp %h got %h", nm, e, a); end end

module test_tap_bypass_scan;
   timeunit 1ns;
   timeprecision 100ps;
   import tap_pkg::*;

   typedef struct packed {
      logic [7:0] din;
      logic [7:0] dout;
   } row_t;

   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   wire logic tck;
   wire logic tms;
   wire logic tdi;
   wire logic tdo;
   wire logic oe_n;
   wire logic dr_upd;
   wire logic tlr;
   logic [DR_W-1:0] dr_par;
   logic [7:0] got;
   int fail_count = 0;
   int checked = 0;
   int upd_cnt = 0;
   int n0;
   row_t rows [4] = '{'{8'h05, 8'h0a}, '{8'h0f, 8'h0e}, '{8'h00, 8'h00}, '{8'h0a, 8'h04}};

   always #2.5 core_clk = ~core_clk;

   tap_bypass_scan #(.DW(DR_W)) uut (
      .core_clk_i(core_clk),
      .rstn_i(rstn),
      .tck_i(tck),
      .tms_i(tms),
      .tdi_i(tdi),
      .tdo_o(tdo),
      .tdo_oe_n_o(oe_n),
      .dr_par_o(dr_par),
      .dr_upd_o(dr_upd),
      .tlr_o(tlr)
   );

   tap_ctrl_model ctl (
      .tck_o(tck),
      .tms_o(tms),
      .tdi_o(tdi),
      .tdo_i(tdo),
      .tdo_oe_n_i(oe_n)
   );

   always @(posedge core_clk) begin
      if (dr_upd === 1'b1) upd_cnt <= upd_cnt + 1;
   end

   // ---------------------------------------------
   // Scan from Run-Test/Idle, LSB first
   // ---------------------------------------------
   task automatic scan(input logic ir, input int n, input logic [7:0] din,
         input logic fin, output logic [7:0] dout);
      dout = 8'h00;
      ctl.idle(1'b1);
      if (ir) ctl.idle(1'b1);
      ctl.idle(1'b0);
      ctl.idle(1'b0);
      dout[0] = ctl.tdo_s;
      `CHK("oe_n shift", 1'b0, ctl.oe_n_s)
      for (int i = 0; i < n; i++) begin
         ctl.step(i == n - 1, din[i]);
         if (i < n - 1) dout[i+1] = ctl.tdo_s;
      end
      `CHK("oe_n exit1", 1'b1, ctl.oe_n_s)
      ctl.idle(1'b1);
      // three ones from update reach reset
      if (fin) repeat (3) ctl.idle(1'b1);
      else ctl.idle(1'b0);
      `CHK("oe_n idle", 1'b1, ctl.oe_n_s)
   endtask

   // Test clock must run while reset passes its synchroniser
   task automatic do_reset;
      fork
         begin
            repeat (12) @(negedge core_clk);
            rstn = 1'b1;
         end
         repeat (14) ctl.idle(1'b1);
      join
      repeat (4) ctl.idle(1'b1);
   endtask

   task tally_and_finish;
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      #20000;
      fail_count++;
      tally_and_finish();
   end

   // ---------------------------------------------
   // Main sequence
   // ---------------------------------------------
   initial begin
      do_reset();
      `CHK("tlr reset", 1'b1, tlr)
      `CHK("oe_n reset", 1'b1, oe_n)
      `CHK("par reset", DR_RESET, dr_par)
      ctl.idle(1'b0);
      repeat (10) @(negedge core_clk);
      `CHK("tlr left", 1'b0, tlr)
      scan(1'b1, IR_W, IR_BYPASS, 1'b0, got);
      `CHK("ir capture", IR_CAPTURE, got)
      n0 = upd_cnt;
      for (int r = 0; r < 4; r++) begin
         scan(1'b0, 4, rows[r].din, 1'b0, got);
         `CHK("bypass out", rows[r].dout, got)
      end
      `CHK("bypass no upd", n0, upd_cnt)
      scan(1'b1, IR_W, IR_USER_DR, 1'b0, got);
      `CHK("ir capture 2", IR_CAPTURE, got)
      scan(1'b0, DR_W, 8'ha5, 1'b0, got);
      `CHK("user capture", DR_RESET, got)
      repeat (10) @(negedge core_clk);
      `CHK("par a5", 8'ha5, dr_par)
      `CHK("upd count", n0 + 1, upd_cnt)
      // Back to back, the second scan sees the first word
      scan(1'b0, DR_W, 8'h3c, 1'b0, got);
      `CHK("user recapture", 8'ha5, got)
      repeat (10) @(negedge core_clk);
      `CHK("par 3c", 8'h3c, dr_par)
      `CHK("upd count 2", n0 + 2, upd_cnt)
      scan(1'b1, IR_W, IR_BYPASS, 1'b0, got);
      n0 = upd_cnt;
      scan(1'b0, 3, 8'h05, 1'b1, got);
      `CHK("bypass 101", {5'h00, 2'h1, BYPASS_CAPTURE}, got)
      repeat (10) @(negedge core_clk);
      `CHK("tlr end", 1'b1, tlr)
      `CHK("par held", 8'h3c, dr_par)
      `CHK("no upd bypass", n0, upd_cnt)
      // Reset in mid shift must release the serial output
      ctl.idle(1'b0);
      ctl.idle(1'b1);
      ctl.idle(1'b0);
      ctl.idle(1'b0);
      `CHK("oe_n mid shift", 1'b0, ctl.oe_n_s)
      @(negedge core_clk);
      rstn = 1'b0;
      do_reset();
      `CHK("tlr mid reset", 1'b1, tlr)
      `CHK("oe_n mid reset", 1'b1, oe_n)
      `CHK("bus mid reset", 1'b1, ctl.oe_n_s)
      `CHK("par mid reset", DR_RESET, dr_par)
      tally_and_finish();
   end
endmodule

`default_nettype wire
